// ---- core/lpcg_defs.vh ----
// lpcg_defs.vh: constants of the low-power clock gating block
// assumes it is included by bare name from the design files under core/
`ifndef LPCG_DEFS_VH
`define LPCG_DEFS_VH

// --------------------------------------------------------------------
// power modes, as driven by the power controller on MODE_I
// --------------------------------------------------------------------
`define LPCG_MODE_W        3
`define LPCG_MODE_RUN      3'h0
`define LPCG_MODE_SLEEP    3'h1
`define LPCG_MODE_LPRUN    3'h2
`define LPCG_MODE_LPSLEEP  3'h3
`define LPCG_MODE_STOP0    3'h4
`define LPCG_MODE_STOP1    3'h5
`define LPCG_MODE_STANDBY  3'h6

// --------------------------------------------------------------------
// debug low-power configuration bit positions
// --------------------------------------------------------------------
`define LPCG_DBG_SLEEP     0
`define LPCG_DBG_STOP      1
`define LPCG_DBG_STANDBY   2

// --------------------------------------------------------------------
// prescalers: three chained stages, ratio is 2**code
// --------------------------------------------------------------------
`define LPCG_DIV_STAGES    3
`define LPCG_DIV_CODE_W    3
`define LPCG_DIV_CNT_W     8
`define LPCG_DIV_CNT_RST   8'h00
`define LPCG_DIV_ONE       8'h01

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define LPCG_MODE_RST      3'h0
`define LPCG_BIT_RST       1'b0

`endif

// ---- core/lpcg_gate.v ----
// lpcg_gate.v: glitch-free gate for one enable-pulse clock
// assumes tick_i is a one-cycle rate pulse on the same clock as clk_i
`timescale 1ns/1ps
`include "lpcg_defs.vh"

module lpcg_gate (
   input  wire clk_i,
   input  wire nrst_i,
   input  wire tick_i,
   input  wire want_i,
   output wire ce_o
);

   reg en_q;

   // --------------------------------------------------------------------
   // gate state
   // --------------------------------------------------------------------
   // the gate moves only while the rate pulse is low, so a pulse is
   // either passed whole or not at all
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         en_q <= `LPCG_BIT_RST;
      end else if (!tick_i) begin
         en_q <= want_i;
      end
   end

   assign ce_o = tick_i & en_q;

endmodule

// ---- core/lpcg_top.v ----
// lpcg_top.v: per-mode clock gating, prescaling and wake control
// Overview of operation
// - flash leaves reset powered; software may power it down in lp run, lp sleep, stop.
// - in stop, a peripheral request starts the fast internal oscillator, routed only to it.
// - in stop, the on-demand oscillator turns off once no peripheral requests it; in run and sleep it stays on.
// - first two serial receivers stay on in stop and wake on start, address, frame.
// - first two-wire controller keeps address detection in stop, waking on a match.
// - in standby, up to five dedicated pins can wake the device.
// - in standby each pin is held pulled up, pulled down or floating as configured.
// - stop 0, stop 1 and standby stop the core clock, losing debug.
// - debug configuration bits keep the debug facility alive in low-power states.
// - run-mode prescalers slow system, bus and peripheral clocks, also before sleep.
// - each bus and peripheral clock can be stopped by software at any time; the SRAM clock only in sleep and lp sleep.
// - dedicated bus and peripheral enable bits control per-peripheral gating.
// - a cleared sleep enable bit stops that clock in sleep, restored on exit.
// - the SRAM clock is separately gateable in sleep and low-power sleep.
// - every optional per-mode function is off after reset until software enables it.
// assumes MODE_I and all config inputs come from logic on CLK_I; OSC_RDY_I and
// WAKE_PIN_I are asynchronous and are synchronised here
`timescale 1ns/1ps
`include "lpcg_defs.vh"

module lpcg_top #(
   parameter NB  = 4,
   parameter NP  = 8,
   parameter NR  = 4,
   parameter NW  = 5,
   parameter NIO = 16
) (
   input  wire                                         CLK_I,
   input  wire                                         NRST_I,
   input  wire [`LPCG_MODE_W-1:0]                      MODE_I,
   input  wire [`LPCG_DIV_STAGES*`LPCG_DIV_CODE_W-1:0] DIV_CODE_I,
   input  wire [NB-1:0]                                BUS_EN_I,
   input  wire [NB-1:0]                                BUS_SM_EN_I,
   input  wire [NP-1:0]                                PER_EN_I,
   input  wire [NP-1:0]                                PER_SM_EN_I,
   input  wire                                         SRAM_SM_EN_I,
   input  wire [2:0]                                   DBG_CFG_I,
   input  wire                                         FLASH_PD_LPRUN_I,
   input  wire                                         FLASH_PD_LPSLEEP_I,
   input  wire                                         FLASH_PD_STOP_I,
   input  wire [NR-1:0]                                OSC_REQ_I,
   input  wire                                         OSC_RDY_I,
   input  wire [1:0]                                   SER_STOP_EN_I,
   input  wire [1:0]                                   SER_START_I,
   input  wire [1:0]                                   SER_ADDR_I,
   input  wire [1:0]                                   SER_FRAME_I,
   input  wire                                         TWI_STOP_EN_I,
   input  wire                                         TWI_ADDR_MATCH_I,
   input  wire [NW-1:0]                                WAKE_PIN_EN_I,
   input  wire [NW-1:0]                                WAKE_PIN_I,
   input  wire [NIO-1:0]                               PULL_UP_CFG_I,
   input  wire [NIO-1:0]                               PULL_DN_CFG_I,
   output wire                                         SYS_CE_O,
   output wire                                         BUS_CE_O,
   output wire                                         PER_CE_O,
   output wire                                         CPU_CE_O,
   output wire                                         DBG_LINK_O,
   output wire [NB-1:0]                                BUS_GCE_O,
   output wire [NP-1:0]                                PER_GCE_O,
   output wire                                         SRAM_CE_O,
   output reg                                          FLASH_PD_O,
   output reg                                          FAST_OSC_ON_O,
   output reg  [NR-1:0]                                FAST_OSC_ROUTE_O,
   output reg  [1:0]                                   SER_RX_ON_O,
   output reg  [1:0]                                   SER_WAKE_O,
   output reg                                          TWI_ADDR_ON_O,
   output reg                                          TWI_WAKE_O,
   output reg                                          STBY_WAKE_O,
   output reg  [NIO-1:0]                               PULL_UP_O,
   output reg  [NIO-1:0]                               PULL_DN_O
);

   localparam NG = NB + NP + 1;

   reg  [`LPCG_MODE_W-1:0]   mode_q;
   reg                       rdy_m_q;
   reg                       rdy_s_q;
   reg  [NW-1:0]             pin_m_q;
   reg  [NW-1:0]             pin_s_q;
   reg  [NW-1:0]             pin_p_q;
   wire                      running;
   wire                      sleeping;
   wire                      stopped;
   wire                      standby;
   wire                      dbg_keep;
   wire [`LPCG_DIV_STAGES:0] tick;
   wire [NG-1:0]             gate_want;
   wire [NG-1:0]             gate_tick;
   wire [NG-1:0]             gate_ce;

   // --------------------------------------------------------------------
   // mode decode
   // --------------------------------------------------------------------
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         mode_q <= `LPCG_MODE_RST;
      end else begin
         mode_q <= MODE_I;
      end
   end

   assign running  = (mode_q == `LPCG_MODE_RUN) || (mode_q == `LPCG_MODE_LPRUN);
   assign sleeping = (mode_q == `LPCG_MODE_SLEEP) || (mode_q == `LPCG_MODE_LPSLEEP);
   assign stopped  = (mode_q == `LPCG_MODE_STOP0) || (mode_q == `LPCG_MODE_STOP1);
   assign standby  = (mode_q == `LPCG_MODE_STANDBY);

   // debug bits keep the core clock and link up in the matching mode
   assign dbg_keep = (sleeping & DBG_CFG_I[`LPCG_DBG_SLEEP])
                   | (stopped  & DBG_CFG_I[`LPCG_DBG_STOP])
                   | (standby  & DBG_CFG_I[`LPCG_DBG_STANDBY]);

   // --------------------------------------------------------------------
   // prescaler chain: system, bus, peripheral rate pulses
   // --------------------------------------------------------------------
   // deep modes freeze the whole chain unless debug must keep running
   assign tick[0] = ~(stopped | standby) | dbg_keep;

   genvar s;
   generate
      for (s = 0; s < `LPCG_DIV_STAGES; s = s + 1) begin : g_div
         reg  [`LPCG_DIV_CNT_W-1:0] cnt_q;
         wire [`LPCG_DIV_CNT_W-1:0] lim;
         assign lim = (`LPCG_DIV_ONE << DIV_CODE_I[s*`LPCG_DIV_CODE_W +: `LPCG_DIV_CODE_W])
                    - `LPCG_DIV_ONE;
         always @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               cnt_q <= `LPCG_DIV_CNT_RST;
            end else if (tick[s]) begin
               cnt_q <= (cnt_q >= lim) ? `LPCG_DIV_CNT_RST : cnt_q + `LPCG_DIV_ONE;
            end
         end
         assign tick[s+1] = tick[s] & (cnt_q >= lim);
      end
   endgenerate

   assign SYS_CE_O   = tick[1];
   assign BUS_CE_O   = tick[2];
   assign PER_CE_O   = tick[3];
   assign CPU_CE_O   = tick[1] & (running | dbg_keep);
   assign DBG_LINK_O = running | sleeping | dbg_keep;

   // --------------------------------------------------------------------
   // per-peripheral and memory gates
   // --------------------------------------------------------------------
   // enables reset to zero upstream; gates themselves reset closed
   assign gate_want = {running | (sleeping & SRAM_SM_EN_I),
                       PER_EN_I & ({NP{running}} | ({NP{sleeping}} & PER_SM_EN_I)),
                       BUS_EN_I & ({NB{running}} | ({NB{sleeping}} & BUS_SM_EN_I))};
   assign gate_tick = {tick[2], {NP{tick[3]}}, {NB{tick[2]}}};

   genvar g;
   generate
      for (g = 0; g < NG; g = g + 1) begin : g_gate
         lpcg_gate u_gate (
            .clk_i  (CLK_I),
            .nrst_i (NRST_I),
            .tick_i (gate_tick[g]),
            .want_i (gate_want[g]),
            .ce_o   (gate_ce[g])
         );
      end
   endgenerate

   assign BUS_GCE_O = gate_ce[NB-1:0];
   assign PER_GCE_O = gate_ce[NB+NP-1:NB];
   assign SRAM_CE_O = gate_ce[NG-1];

   // --------------------------------------------------------------------
   // asynchronous inputs
   // --------------------------------------------------------------------
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rdy_m_q <= `LPCG_BIT_RST;
         rdy_s_q <= `LPCG_BIT_RST;
         pin_m_q <= {NW{1'b0}};
         pin_s_q <= {NW{1'b0}};
         pin_p_q <= {NW{1'b0}};
      end else begin
         rdy_m_q <= OSC_RDY_I;
         rdy_s_q <= rdy_m_q;
         pin_m_q <= WAKE_PIN_I;
         pin_s_q <= pin_m_q;
         pin_p_q <= pin_s_q;
      end
   end

   // --------------------------------------------------------------------
   // flash, on-demand oscillator, stop and standby wake logic
   // --------------------------------------------------------------------
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         FLASH_PD_O       <= `LPCG_BIT_RST;
         FAST_OSC_ON_O    <= `LPCG_BIT_RST;
         FAST_OSC_ROUTE_O <= {NR{1'b0}};
         SER_RX_ON_O      <= 2'h0;
         SER_WAKE_O       <= 2'h0;
         TWI_ADDR_ON_O    <= `LPCG_BIT_RST;
         TWI_WAKE_O       <= `LPCG_BIT_RST;
         STBY_WAKE_O      <= `LPCG_BIT_RST;
         PULL_UP_O        <= {NIO{1'b0}};
         PULL_DN_O        <= {NIO{1'b0}};
      end else begin
         FLASH_PD_O <= ((mode_q == `LPCG_MODE_LPRUN) & FLASH_PD_LPRUN_I)
                     | ((mode_q == `LPCG_MODE_LPSLEEP) & FLASH_PD_LPSLEEP_I)
                     | (stopped & FLASH_PD_STOP_I);
         // outside deep modes the oscillator also backs the system clock
         FAST_OSC_ON_O <= running | sleeping | (stopped & (|OSC_REQ_I));
         // routing waits for the oscillator to settle so a feed starts clean
         FAST_OSC_ROUTE_O <= (stopped & rdy_s_q) ? OSC_REQ_I : {NR{1'b0}};
         SER_RX_ON_O   <= {2{stopped}} & SER_STOP_EN_I;
         SER_WAKE_O    <= {2{stopped}} & SER_STOP_EN_I
                        & (SER_START_I | SER_ADDR_I | SER_FRAME_I);
         TWI_ADDR_ON_O <= stopped & TWI_STOP_EN_I;
         TWI_WAKE_O    <= stopped & TWI_STOP_EN_I & TWI_ADDR_MATCH_I;
         STBY_WAKE_O   <= standby & (|(WAKE_PIN_EN_I & pin_s_q & ~pin_p_q));
         // a pin with both pulls set takes the pull-up
         PULL_UP_O <= {NIO{standby}} & PULL_UP_CFG_I;
         PULL_DN_O <= {NIO{standby}} & PULL_DN_CFG_I & ~PULL_UP_CFG_I;
      end
   end

endmodule

// ---- verif/lpcg_far_model.sv ----
// lpcg_far_model.sv: stop-capable peripheral with its fast oscillator warm-up
// assumes the clock of lpcg_top; the bench moves wish_i on falling edges
`timescale 1ns/1ps
module lpcg_far_model #(
   parameter NR = 4
) (
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   input  wire logic          osc_on_i,
   input  wire logic [NR-1:0] wish_i,
   output logic               osc_rdy_o,
   output logic [NR-1:0]      osc_req_o
);
   // ------------------------------------------------------------
   // oscillator settles after two cycles and is gone as soon as it stops
   // ------------------------------------------------------------
   logic [1:0] warm_q;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         warm_q    <= 2'h0;
         osc_req_o <= {NR{1'b0}};
      end else begin
         warm_q    <= osc_on_i ? {warm_q[0], 1'b1} : 2'h0;
         osc_req_o <= wish_i;
      end
   end
   assign osc_rdy_o = warm_q[1] & osc_on_i;
endmodule

// ---- verif/lpcg_monitor.sv ----
// lpcg_monitor.sv: port checks for lpcg_top
// assumes it is bound into lpcg_top and lpcg_defs.vh is on the include path
`timescale 1ns/1ps
`include "lpcg_defs.vh"
module lpcg_monitor #(
   parameter NP  = 8,
   parameter NR  = 4,
   parameter NIO = 16
) (
   input wire logic                    CLK_I, NRST_I, CPU_CE_O, DBG_LINK_O, PER_CE_O,
   input wire logic                    FLASH_PD_O, FAST_OSC_ON_O,
   input wire logic [`LPCG_MODE_W-1:0] MODE_I,
   input wire logic [2:0]              DBG_CFG_I,
   input wire logic [1:0]              SER_STOP_EN_I, SER_START_I, SER_WAKE_O,
   input wire logic [NP-1:0]           PER_EN_I, PER_GCE_O,
   input wire logic [NR-1:0]           OSC_REQ_I, FAST_OSC_ROUTE_O,
   input wire logic [NIO-1:0]          PULL_UP_CFG_I, PULL_DN_CFG_I, PULL_UP_O, PULL_DN_O
);
   // ------------------------------------------------------------
   // registered outputs lag MODE_I by two edges, combinational ones by one
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   a_flash_run_on:
      assert property ($past(MODE_I, 2) == `LPCG_MODE_RUN |-> !FLASH_PD_O) else $error("flash down in run");
   a_osc_on_demand:
      assert property ($past(MODE_I, 2) == `LPCG_MODE_STOP1 |-> FAST_OSC_ON_O == |$past(OSC_REQ_I))
      else $error("oscillator does not follow requests");
   a_route_only_req:
      assert property ((FAST_OSC_ROUTE_O & ~$past(OSC_REQ_I)) == {NR{1'b0}}) else $error("bad route");
   a_debug_lost:
      assert property ($past(MODE_I) inside {`LPCG_MODE_STOP0, `LPCG_MODE_STOP1, `LPCG_MODE_STANDBY}
         && DBG_CFG_I == 3'h0 |-> !DBG_LINK_O && !CPU_CE_O) else $error("core clock runs in deep mode");
   a_debug_kept:
      assert property ($past(MODE_I) == `LPCG_MODE_STOP0 && DBG_CFG_I[1] |-> DBG_LINK_O)
      else $error("debug link lost while kept");
   a_gate_shut:
      assert property (!PER_CE_O && !PER_EN_I[0] |=> !PER_GCE_O[0]) else $error("gate not closed");
   a_serial_wake:
      assert property ($past(MODE_I, 2) == `LPCG_MODE_STOP0 && $past(SER_STOP_EN_I[0] && SER_START_I[0])
         |-> SER_WAKE_O[0]) else $error("no serial wake");
   a_standby_pulls:
      assert property ($past(MODE_I, 2) == `LPCG_MODE_STANDBY |-> PULL_UP_O == $past(PULL_UP_CFG_I)
         && PULL_DN_O == $past(PULL_DN_CFG_I & ~PULL_UP_CFG_I)) else $error("standby pulls wrong");
endmodule
bind lpcg_top lpcg_monitor #(.NP(NP), .NR(NR), .NIO(NIO)) mon (.*);

// ---- verif/test_low_power_clock_gating.sv ----
// test_low_power_clock_gating.sv: directed bench for lpcg_top
// assumes the design under core/ and lpcg_defs.vh on the include path
`timescale 1ns/1ps
`include "lpcg_defs.vh"
module test_low_power_clock_gating;
   logic        CLK_I, NRST_I, SRAM_SM_EN_I, TWI_STOP_EN_I, TWI_ADDR_MATCH_I;
   logic        FLASH_PD_LPRUN_I, FLASH_PD_LPSLEEP_I, FLASH_PD_STOP_I;
   logic [2:0]  MODE_I, DBG_CFG_I;
   logic [8:0]  DIV_CODE_I;
   logic [3:0]  BUS_EN_I, BUS_SM_EN_I, wish;
   logic [7:0]  PER_EN_I, PER_SM_EN_I, t [9];
   logic [1:0]  SER_STOP_EN_I, SER_START_I, SER_ADDR_I, SER_FRAME_I;
   logic [4:0]  WAKE_PIN_EN_I, WAKE_PIN_I;
   logic [15:0] PULL_UP_CFG_I, PULL_DN_CFG_I;
   wire         SYS_CE_O, BUS_CE_O, PER_CE_O, CPU_CE_O, DBG_LINK_O, SRAM_CE_O, FLASH_PD_O;
   wire         FAST_OSC_ON_O, TWI_ADDR_ON_O, TWI_WAKE_O, STBY_WAKE_O, OSC_RDY_I;
   wire [3:0]   BUS_GCE_O, FAST_OSC_ROUTE_O, OSC_REQ_I;
   wire [7:0]   PER_GCE_O;
   wire [1:0]   SER_RX_ON_O, SER_WAKE_O;
   wire [15:0]  PULL_UP_O, PULL_DN_O;
   int          n_mismatch, tests_run;
   lpcg_top dut (.*);
   lpcg_far_model far (.clk_i(CLK_I), .nrst_i(NRST_I), .osc_on_i(FAST_OSC_ON_O),
      .wish_i(wish), .osc_rdy_o(OSC_RDY_I), .osc_req_o(OSC_REQ_I));
   // ------------------------------------------------------------
   // access tasks; every task starts and ends on a falling edge
   // ------------------------------------------------------------
   task chk(input string nm, input logic [39:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task finish_test;
      if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // pulse tallies per output over n cycles, sampled where they are settled
   task count(input int n);
      logic [8:0] s;
      t = '{default: 8'h00};
      repeat (n) begin
         @(negedge CLK_I);
         s = {STBY_WAKE_O, BUS_GCE_O[0], PER_GCE_O[2], PER_GCE_O[0], SRAM_CE_O, CPU_CE_O,
              PER_CE_O, BUS_CE_O, SYS_CE_O};
         for (int k = 0; k < 9; k++) t[k] += s[k];
      end
   endtask
   task go(input logic [2:0] m);
      MODE_I = m;
      repeat (3) @(negedge CLK_I);
   endtask
   initial begin
      CLK_I = 1'b0;
      forever #50 CLK_I = ~CLK_I;
   end
   initial begin
      {NRST_I, MODE_I, DIV_CODE_I, DBG_CFG_I, BUS_EN_I, BUS_SM_EN_I, PER_EN_I} = 32'h0;
      {PER_SM_EN_I, SRAM_SM_EN_I, wish, SER_START_I, SER_ADDR_I, SER_FRAME_I} = 19'h0;
      {TWI_ADDR_MATCH_I, WAKE_PIN_I} = 6'h00;
      {FLASH_PD_LPRUN_I, FLASH_PD_LPSLEEP_I, FLASH_PD_STOP_I, SER_STOP_EN_I, TWI_STOP_EN_I} = 6'h2b;
      {WAKE_PIN_EN_I, PULL_UP_CFG_I, PULL_DN_CFG_I} = {5'h10, 16'h00f3, 16'h0f30};
      repeat (3) @(negedge CLK_I);
      NRST_I = 1'b1;
      repeat (2) @(negedge CLK_I);
      chk("reset", {FLASH_PD_O, SER_RX_ON_O, TWI_ADDR_ON_O, PER_GCE_O, DBG_LINK_O}, 1);
      for (int c = 0; c < 4; c++) begin
         DIV_CODE_I = (c == 3) ? 9'h049 : 9'(c);
         repeat (16) @(negedge CLK_I);
         count(32);
         chk("ticks", {t[0], t[1], t[2]}, c == 3 ? 24'h100804 : {3{8'h20 >> c}});
      end
      DIV_CODE_I = 9'h001;
      {BUS_EN_I, PER_EN_I, PER_SM_EN_I} = {4'h1, 8'h05, 8'h01};
      repeat (8) @(negedge CLK_I);
      count(32);
      chk("run_gates", {t[3], t[4], t[5], t[6], t[7]}, 40'h1010101010);
      go(`LPCG_MODE_SLEEP);
      count(32);
      chk("sleep_gates", {t[3], t[4], t[5], t[6], t[7]}, 40'h0000100000);
      {SRAM_SM_EN_I, BUS_SM_EN_I, DBG_CFG_I} = {1'b1, 4'h1, 3'h1};
      repeat (4) @(negedge CLK_I);
      count(32);
      chk("sleep_sram", {t[3], t[4], t[7]}, 24'h101010);
      go(`LPCG_MODE_RUN);
      count(32);
      chk("run_again", t[6], 8'h10);
      PER_EN_I = 8'h04;
      repeat (4) @(negedge CLK_I);
      count(32);
      chk("run_shut", {t[5], t[6]}, 16'h0010);
      DBG_CFG_I = 3'h2;
      go(`LPCG_MODE_STOP0);
      count(32);
      chk("stop_dbg", {DBG_LINK_O, t[3], t[5], SER_RX_ON_O, TWI_ADDR_ON_O}, 20'h88003);
      DBG_CFG_I = 3'h0;
      // start/address/frame events on both channels in turn, only channel 0 enabled, then the address match
      for (int k = 0; k < 4; k++) begin
         {TWI_ADDR_MATCH_I, SER_FRAME_I, SER_ADDR_I, SER_START_I} = 7'h03 << (2 * k);
         @(negedge CLK_I);
         chk("wake", {TWI_WAKE_O, SER_WAKE_O}, k == 3 ? 3'h4 : 3'h1);
      end
      {TWI_ADDR_MATCH_I, SER_FRAME_I, SER_ADDR_I, SER_START_I} = 7'h00;
      DIV_CODE_I = 9'h049;
      go(`LPCG_MODE_LPRUN);
      chk("flash_lprun", FLASH_PD_O, 1);
      go(`LPCG_MODE_LPSLEEP);
      chk("flash_lpsleep", FLASH_PD_O, 0);
      go(`LPCG_MODE_STOP1);
      chk("stop1", {FLASH_PD_O, FAST_OSC_ON_O, DBG_LINK_O}, 3'h4);
      wish = 4'h4;
      for (int i = 0; FAST_OSC_ROUTE_O !== 4'h4; i++) begin
         if (i == 20) begin
            n_mismatch++;
            finish_test();
         end
         @(negedge CLK_I);
      end
      chk("osc_on", {FAST_OSC_ON_O, FAST_OSC_ROUTE_O}, 5'h14);
      wish = 4'h0;
      repeat (3) @(negedge CLK_I);
      chk("osc_off", {FAST_OSC_ON_O, FAST_OSC_ROUTE_O}, 0);
      go(`LPCG_MODE_STANDBY);
      chk("pulls", {PULL_UP_O, PULL_DN_O, DBG_LINK_O}, 33'h001e61e00);
      DBG_CFG_I = 3'h4;
      @(negedge CLK_I);
      chk("stby_dbg", DBG_LINK_O, 1);
      DBG_CFG_I = 3'h0;
      WAKE_PIN_I = 5'h01;
      count(8);
      chk("wake_masked", t[8], 0);
      WAKE_PIN_I = 5'h11;
      count(8);
      chk("wake_pin", t[8], 1);
      finish_test();
   end
endmodule
